// *** psc_regs.vh ***
// register offsets, field positions, codes and timing for the port controller
// assumes: included by the design files by bare name, no process in here
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PSC_ADDR_MODE 8'h00
`define PSC_ADDR_ENABLE 8'h04
`define PSC_ADDR_CMD 8'h08
`define PSC_ADDR_STATUS 8'h0C
`define PSC_ADDR_POWER 8'h10
`define PSC_ADDR_THR0 8'h20
`define PSC_ADDR_THR3 8'h2C
// ----------------------------------------------------------------
// field positions (bit index of port 0)
// ----------------------------------------------------------------
`define PSC_EN_DET 0
`define PSC_EN_CLS 4
`define PSC_EN_DISC 8
`define PSC_EN_HP 12
`define PSC_EN_EXT 16
`define PSC_CMD_DET 0
`define PSC_CMD_CLS 4
`define PSC_CMD_ON 8
`define PSC_CMD_OFF 12
`define PSC_CMD_GRST 31
// ----------------------------------------------------------------
// operating mode codes and reset values
// ----------------------------------------------------------------
`define PSC_MODE_SHUT 2'h0
`define PSC_MODE_MAN 2'h1
`define PSC_MODE_SEMI 2'h2
`define PSC_MODE_AUTO 2'h3
`define PSC_MODE_RST_AUTO 8'hFF
`define PSC_EN_RST_AUTO 32'h00000FFF
// ----------------------------------------------------------------
// detection result codes
// ----------------------------------------------------------------
`define PSC_DET_UNKNOWN 3'h0
`define PSC_DET_SHORT 3'h1
`define PSC_DET_CAP_HIGH 3'h2
`define PSC_DET_LOW 3'h3
`define PSC_DET_GOOD 3'h4
`define PSC_DET_HIGH 3'h5
`define PSC_DET_OPEN 3'h6
`define PSC_DET_VOLT_OUT 3'h7
// ----------------------------------------------------------------
// signature limits in 100 ohm units, thresholds in mA, power in 0.1 W
// ----------------------------------------------------------------
`define PSC_RES_SHORT 12'h018
`define PSC_RES_GOOD_LO 12'h0AA
`define PSC_RES_GOOD_HI 12'h122
`define PSC_RES_OPEN 12'h1F4
`define PSC_CUT_C1 10'h070
`define PSC_CUT_C2 10'h0CE
`define PSC_CUT_C3 10'h177
`define PSC_CUT_C4 10'h27E
`define PSC_LIM_STD 10'h1A9
`define PSC_LIM_C4 10'h352
`define PSC_MAX_POWER_DW 10'h384
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSC_CLK_MHZ 100
`define PSC_WAIT_MS 100
`define PSC_MID_WAIT_MS 2000
`endif

// *** psc_sig_encode.v ***
// signature encoder: turns one port's measurement into a detection result code
// assumes: measurement inputs are stable on the cycle the step is done
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_sig_encode (
  input wire [11:0] res, // resistance, 100 ohm units
  input wire v_low, // port under 1 V at first forced current
  input wire cap_high, // load capacitance too high
  input wire volt_high, // port voltage outside detect range
  output reg [2:0] result
);
  // ----------------------------------------------------------------
  // priority encode, open wins over too high
  // ----------------------------------------------------------------
  always @* begin
    if (v_low) begin
      result = `PSC_DET_SHORT;
    end else if (volt_high) begin
      result = `PSC_DET_VOLT_OUT;
    end else if (cap_high) begin
      result = `PSC_DET_CAP_HIGH;
    end else if (res < `PSC_RES_SHORT) begin
      result = `PSC_DET_SHORT;
    end else if (res > `PSC_RES_OPEN) begin
      result = `PSC_DET_OPEN;
    end else if (res > `PSC_RES_GOOD_HI) begin
      result = `PSC_DET_HIGH;
    end else if (res >= `PSC_RES_GOOD_LO) begin
      result = `PSC_DET_GOOD;
    end else begin
      result = `PSC_DET_LOW;
    end
  end
endmodule // psc_sig_encode
`default_nettype wire

// *** psc_class_thresh.v ***
// class to threshold table: cut and limit currents for one port
// assumes: class code 0 to 4, other codes treated as class 0
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_class_thresh (
  input wire [2:0] cls, // class result
  output reg [9:0] cut_ma, // overcurrent cut threshold
  output reg [9:0] lim_ma // current limit threshold
);
  // ----------------------------------------------------------------
  // lookup, class 0 and 3 share a row
  // ----------------------------------------------------------------
  always @* begin
    cut_ma = `PSC_CUT_C3;
    lim_ma = `PSC_LIM_STD;
    case (cls)
      3'h1: cut_ma = `PSC_CUT_C1;
      3'h2: cut_ma = `PSC_CUT_C2;
      3'h4: begin
        cut_ma = `PSC_CUT_C4;
        lim_ma = `PSC_LIM_C4;
      end
      default: cut_ma = `PSC_CUT_C3;
    endcase
  end
endmodule // psc_class_thresh
`default_nettype wire

// *** psc_port_ctrl.v ***
// four-port mode, detection sequencing and power control with axi4-lite registers
// assumes: analog front end on the same clock, strap pins asynchronous
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
// Overview of operation
// - four independent ports, one mode each
// - mode codes: 11 pin, 10 semi, 01 manual
// - manual: one cycle per command, power on order
// - semi-auto: repeat detection, power on command only
// - pin mode: auto power, auto thresholds
// - pin mode valid only with strap high throughout
// - shutdown: no detection, never powered
// - current limit fault removes power always
// - disconnect removes power when enabled
// - host power-off honoured any time
// - reset from pin or global bit, straps sampled
// - straps latched only during reset
// - strap high: all ports autonomous at reset
// - class sets cut and limit thresholds
// - auto thresholds only after strap-high reset
// - midspan strap selects midspan detection pacing
// - extended class needs high power and extended
// - refuse loads above grade power limit in pin mode
// - forced current then forced voltage, both valid
// - under 1 V aborts as short circuit
// - resistance bands: short, low, good, high
// - unknown, capacitance, open, voltage results
// - wait 100 ms or 2 s between cycles
module psc_port_ctrl #(
  parameter WAIT_CYC = `PSC_WAIT_MS * 1000 * `PSC_CLK_MHZ, // normal pacing
  parameter MID_WAIT_CYC = `PSC_MID_WAIT_MS * 1000 * `PSC_CLK_MHZ, // midspan pacing
  parameter [9:0] MAX_POWER_DW = `PSC_MAX_POWER_DW // grade power limit
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire standalone_select_pin,
  input wire midspan_select_pin,
  input wire [3:0] step_done,
  input wire [47:0] signature_resistance,
  input wire [3:0] meas_v_low,
  input wire [3:0] load_capacitance_high,
  input wire [3:0] meas_volt_high,
  input wire [11:0] class_result,
  input wire [39:0] req_power_dw,
  input wire [3:0] current_limit_fault,
  input wire [3:0] disconnect_event,
  output wire [3:0] port_power_en,
  output wire [3:0] step_req,
  output wire [7:0] step_code,
  output wire [39:0] overcurrent_cut_threshold,
  output wire [39:0] current_limit_threshold,
  output reg [3:0] ext_class_en,
  output reg midspan_timing
);
  // ----------------------------------------------------------------
  // local codes
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0; // waiting for a trigger
  localparam [2:0] S_FI = 3'h1; // forced current pair
  localparam [2:0] S_FV = 3'h2; // forced voltage pair
  localparam [2:0] S_CLS = 3'h3; // classification
  localparam [2:0] S_WAIT = 3'h4; // pacing between cycles
  localparam [1:0] STEP_FI = 2'h0;
  localparam [1:0] STEP_FV = 2'h1;
  localparam [1:0] STEP_CLS = 2'h2;

  // byte-lane merge of a register write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // decode of any mapped offset
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `PSC_ADDR_MODE) || (a == `PSC_ADDR_ENABLE) ||
        (a == `PSC_ADDR_CMD) || (a == `PSC_ADDR_STATUS) ||
        (a == `PSC_ADDR_POWER) ||
        (a >= `PSC_ADDR_THR0 && a <= `PSC_ADDR_THR3 && a[1:0] == 2'h0);
    end
  endfunction

  // ----------------------------------------------------------------
  // strap synchronisers and latches
  // ----------------------------------------------------------------
  reg auto_s1, auto_s2; // standalone strap sync
  reg mid_s1, mid_s2; // midspan strap sync
  reg strap_auto; // standalone strap caught at reset
  reg strap_mid; // midspan strap caught at reset
  reg soft_rst; // global reset bit pulse
  wire int_rst = !rst_n || soft_rst; // any reset source

  // two-stage sync, no reset so they settle during reset
  always @(posedge clock) begin
    auto_s1 <= standalone_select_pin;
    auto_s2 <= auto_s1;
    mid_s1 <= midspan_select_pin;
    mid_s2 <= mid_s1;
  end

  // straps sampled only while reset holds
  always @(posedge clock) begin
    if (int_rst) begin
      strap_auto <= auto_s2;
      strap_mid <= mid_s2;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg [7:0] aw_addr; // captured write address
  reg [31:0] w_data; // captured write data
  reg [3:0] w_strb; // captured byte enables
  reg [7:0] mode; // port_operating_mode, 2 bits per port
  reg [31:0] enables; // detect, class, disconnect, high power, extended
  reg [15:0] cmd; // one-cycle command pulses
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid; // both held
  wire [31:0] wr_val_mode = merge({24'h000000, mode}, w_data, w_strb);
  wire [31:0] wr_val_en = merge(enables, w_data, w_strb);
  wire [31:0] wr_val_cmd = merge(32'h00000000, w_data, w_strb);

  // handshake: take address and data in any order, answer once both held
  always @(posedge clock) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? 2'h0 : 2'h2; // slverr when unmapped
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file writes, reset values follow the straps
  always @(posedge clock) begin
    cmd <= 16'h0000;
    soft_rst <= 1'b0;
    if (int_rst) begin
      mode <= auto_s2 ? `PSC_MODE_RST_AUTO : 8'h00;
      enables <= auto_s2 ? `PSC_EN_RST_AUTO : 32'h00000000;
    end else if (wr_go) begin
      if (aw_addr == `PSC_ADDR_MODE) begin
        mode <= wr_val_mode[7:0];
      end else if (aw_addr == `PSC_ADDR_ENABLE) begin
        enables <= {12'h000, wr_val_en[19:0]};
      end else if (aw_addr == `PSC_ADDR_CMD) begin
        cmd <= wr_val_cmd[15:0];
        soft_rst <= wr_val_cmd[`PSC_CMD_GRST];
      end
    end
  end

  // ----------------------------------------------------------------
  // per-port sequencers
  // ----------------------------------------------------------------
  wire [23:0] port_stat; // result and class, 8 bits per port, bits 2:0 and 6:4 used
  wire [31:0] port_stat_w; // status word
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      reg [2:0] st; // sequencer state
      reg [2:0] det_q; // latest detection result
      reg [2:0] cls_q; // latest class
      reg pwr; // power applied
      reg req; // step request pulse
      reg [1:0] step; // step kind
      reg auto_go; // pin-mode power-on pulse
      reg [27:0] cnt; // pacing counter
      reg [9:0] cut_q; // cut threshold
      reg [9:0] lim_q; // limit threshold
      wire [2:0] enc; // encoded signature
      wire [9:0] t_cut;
      wire [9:0] t_lim;
      wire [1:0] m = mode[2*p +: 2];
      // pin mode needs the strap high at reset and now
      wire pin_ok = strap_auto && auto_s2;
      wire [1:0] em = (m == `PSC_MODE_AUTO && !pin_ok) ? `PSC_MODE_SHUT : m;
      wire [2:0] cls_in = class_result[3*p +: 3];
      wire fits = req_power_dw[10*p +: 10] <= MAX_POWER_DW;
      wire [27:0] pace = strap_mid ? MID_WAIT_CYC[27:0] : WAIT_CYC[27:0];
      wire done = step_done[p];

      psc_sig_encode u_enc (
        .res(signature_resistance[12*p +: 12]),
        .v_low(meas_v_low[p]),
        .cap_high(load_capacitance_high[p]),
        .volt_high(meas_volt_high[p]),
        .result(enc)
      );

      psc_class_thresh u_thr (
        .cls(cls_q),
        .cut_ma(t_cut),
        .lim_ma(t_lim)
      );

      // power control: every removal cause beats any power-on
      always @(posedge clock) begin
        if (int_rst) begin
          pwr <= 1'b0;
        end else if (em == `PSC_MODE_SHUT) begin
          pwr <= 1'b0;
        end else if (cmd[`PSC_CMD_OFF + p]) begin
          pwr <= 1'b0;
        end else if (current_limit_fault[p]) begin
          pwr <= 1'b0;
        end else if (disconnect_event[p] && enables[`PSC_EN_DISC + p]) begin
          pwr <= 1'b0;
        end else if (cmd[`PSC_CMD_ON + p] && em != `PSC_MODE_AUTO &&
            (!enables[`PSC_EN_HP + p] || det_q == `PSC_DET_GOOD)) begin
          pwr <= 1'b1;
        end else if (auto_go) begin
          pwr <= 1'b1;
        end
      end

      // detection and classification sequence
      always @(posedge clock) begin
        req <= 1'b0;
        auto_go <= 1'b0;
        if (int_rst) begin
          st <= S_IDLE;
          det_q <= `PSC_DET_UNKNOWN;
          cls_q <= 3'h0;
          step <= STEP_FI;
          cnt <= 28'h0000000;
        end else if (em == `PSC_MODE_SHUT) begin
          st <= S_IDLE;
        end else begin
          case (st)
            S_IDLE: begin
              if (em == `PSC_MODE_MAN) begin
                if (cmd[`PSC_CMD_DET + p]) begin
                  st <= S_FI;
                  req <= 1'b1;
                  step <= STEP_FI;
                  det_q <= `PSC_DET_UNKNOWN;
                end else if (cmd[`PSC_CMD_CLS + p]) begin
                  st <= S_CLS;
                  req <= 1'b1;
                  step <= STEP_CLS;
                end
              end else if (enables[`PSC_EN_DET + p] && !pwr) begin
                st <= S_FI;
                req <= 1'b1;
                step <= STEP_FI;
                det_q <= `PSC_DET_UNKNOWN;
              end
            end
            S_FI: begin
              if (done && enc == `PSC_DET_GOOD) begin
                st <= S_FV;
                req <= 1'b1;
                step <= STEP_FV;
              end else if (done) begin
                det_q <= enc;
                st <= (em == `PSC_MODE_MAN) ? S_IDLE : S_WAIT;
                cnt <= pace;
              end
            end
            S_FV: begin
              if (done) begin
                det_q <= enc;
                if (enc == `PSC_DET_GOOD && enables[`PSC_EN_CLS + p] &&
                    em != `PSC_MODE_MAN) begin
                  st <= S_CLS;
                  req <= 1'b1;
                  step <= STEP_CLS;
                end else begin
                  auto_go <= (em == `PSC_MODE_AUTO) && (enc == `PSC_DET_GOOD) && fits;
                  st <= (em == `PSC_MODE_MAN) ? S_IDLE : S_WAIT;
                  cnt <= pace;
                end
              end
            end
            S_CLS: begin
              if (done) begin
                cls_q <= cls_in;
                auto_go <= (em == `PSC_MODE_AUTO) && (det_q == `PSC_DET_GOOD) && fits;
                st <= (em == `PSC_MODE_MAN) ? S_IDLE : S_WAIT;
                cnt <= pace;
              end
            end
            S_WAIT: begin
              if (cnt <= 28'h0000001) begin
                st <= S_IDLE;
              end else begin
                cnt <= cnt - 28'h0000001;
              end
            end
            default: st <= S_IDLE;
          endcase
        end
      end

      // thresholds: class table in pin mode, host writes otherwise
      always @(posedge clock) begin
        if (int_rst) begin
          cut_q <= `PSC_CUT_C3;
          lim_q <= `PSC_LIM_STD;
        end else if (em == `PSC_MODE_AUTO && strap_auto) begin
          cut_q <= t_cut;
          lim_q <= t_lim;
        end else if (wr_go && aw_addr == `PSC_ADDR_THR0 + 8'h04 * p) begin
          cut_q <= w_data[9:0];
          lim_q <= w_data[25:16];
        end
      end

      assign port_power_en[p] = pwr;
      assign step_req[p] = req;
      assign step_code[2*p +: 2] = step;
      assign overcurrent_cut_threshold[10*p +: 10] = cut_q;
      assign current_limit_threshold[10*p +: 10] = lim_q;
      assign port_stat_w[8*p +: 8] = {1'b0, cls_q, 1'b0, det_q};
    end
  endgenerate
  assign port_stat = port_stat_w[23:0];

  // extended classification and midspan pacing flags
  always @(posedge clock) begin
    if (int_rst) begin
      ext_class_en <= 4'h0;
      midspan_timing <= 1'b0;
    end else begin
      ext_class_en <= enables[`PSC_EN_HP +: 4] & enables[`PSC_EN_EXT +: 4];
      midspan_timing <= strap_mid;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  reg [31:0] rd_val; // decoded read word
  integer k;
  always @* begin
    rd_val = 32'h00000000;
    if (s_axi_araddr == `PSC_ADDR_MODE) begin
      rd_val = {24'h000000, mode};
    end else if (s_axi_araddr == `PSC_ADDR_ENABLE) begin
      rd_val = enables;
    end else if (s_axi_araddr == `PSC_ADDR_STATUS) begin
      rd_val = {port_stat_w[31:24], port_stat};
    end else if (s_axi_araddr == `PSC_ADDR_POWER) begin
      rd_val = {22'h000000, strap_mid, strap_auto, ext_class_en, port_power_en};
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (s_axi_araddr == `PSC_ADDR_THR0 + 8'h04 * k[7:0]) begin
          rd_val = {6'h00, current_limit_threshold[10*k +: 10],
            6'h00, overcurrent_cut_threshold[10*k +: 10]};
        end
      end
    end
  end

  // one read at a time, data registered
  always @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // psc_port_ctrl
`default_nettype wire

// *** psc_port_ctrl_assertions.sv ***
// checker: port-level timing of the port controller
// assumes: bound to psc_port_ctrl, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module psc_port_ctrl_assertions (
  input wire logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [3:0] step_done, step_req, meas_v_low, meas_volt_high,
  input wire logic [3:0] load_capacitance_high, current_limit_fault, port_power_en,
  input wire logic [7:0] step_code,
  input wire logic [47:0] signature_resistance
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // both write channels taken on one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ready drops, then the response shows
  sequence s_wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  // forced-current step on port 0 finished with a good slope
  sequence s_fi_good;
    step_done[0] && step_code[1:0] == 2'h0 && !meas_v_low[0] && !meas_volt_high[0]
      && !load_capacitance_high[0] && signature_resistance[11:0] >= 12'h0AA
      && signature_resistance[11:0] <= 12'h122;
  endsequence
  a_write_response: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response out of time");
  a_read_response: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response out of time");
  a_fv_follows_fi: assert property (s_fi_good |=> step_req[0] && step_code[1:0] == 2'h1)
    else $error("forced voltage step missing");
  a_short_aborts: assert property (step_done[0] && step_code[1:0] == 2'h0 && meas_v_low[0] |=> !step_req[0] [*3])
    else $error("detection not aborted");
  a_fault_power_off: assert property (current_limit_fault[0] && port_power_en[0] |-> ##[1:2] !port_power_en[0])
    else $error("power kept after fault");
  a_step_one_pulse: assert property ((step_req & $past(step_req)) == 4'h0)
    else $error("step request longer than one cycle");
  a_powered_no_detect: assert property ((step_req & port_power_en & $past(port_power_en)) == 4'h0)
    else $error("detection while powered");
  a_reset_no_power: assert property ($rose(rst_n) |-> port_power_en == 4'h0 && step_req == 4'h0)
    else $error("activity out of reset");
endmodule // psc_port_ctrl_assertions
`default_nettype wire

// *** psc_fe_model.sv ***
// front end and cable model: answers each step three cycles after it is asked
// assumes: same clock as the controller
`timescale 1ns/1ps
`default_nettype none
module psc_fe_model (
  input wire logic clock, rst_n, fe_vlow,
  input wire logic [3:0] step_req,
  input wire logic [11:0] fe_res,
  input wire logic [2:0] fe_cls,
  output logic [3:0] step_done, meas_v_low, load_capacitance_high, meas_volt_high,
  output logic [47:0] signature_resistance,
  output logic [11:0] class_result
);
  logic [3:0] d1, d2; // request delay line
  always @(posedge clock) begin
    d1 <= rst_n ? step_req : 4'h0;
    d2 <= d1;
    step_done <= d2;
  end
  // results valid only with done, inverted junk otherwise
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      signature_resistance[12*p+:12] = step_done[p] ? fe_res : ~fe_res;
      class_result[3*p+:3] = step_done[p] ? fe_cls : ~fe_cls;
      meas_v_low[p] = step_done[p] ? fe_vlow : ~fe_vlow;
      load_capacitance_high[p] = ~step_done[p];
      meas_volt_high[p] = ~step_done[p];
    end
  end
endmodule // psc_fe_model
`default_nettype wire

// *** test_pse_port_mode_detect_control.sv ***
// testbench: register access, semi-auto results and power, pin-mode run
// assumes: design, header, checker and front end model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module test_pse_port_mode_detect_control;
  logic clock = 1'b0, rst_n = 1'b0, fe_vlow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic standalone_select_pin = 1'b0, midspan_select_pin = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, step_code;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, current_limit_fault = 4'h0, disconnect_event = 4'h0;
  logic [39:0] req_power_dw = 40'h0, overcurrent_cut_threshold, current_limit_threshold;
  logic [11:0] fe_res = 12'h0FA, class_result;
  logic [2:0] fe_cls = 3'h4;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, midspan_timing;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] step_done, meas_v_low, load_capacitance_high, meas_volt_high;
  logic [3:0] port_power_en, step_req, ext_class_en;
  logic [47:0] signature_resistance;
  int n_fail = 0, compares = 0;
  psc_port_ctrl #(.WAIT_CYC(20), .MID_WAIT_CYC(40)) i_dut (.*);
  psc_fe_model i_fe (.*);
  always #5 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // write: both channels offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) n_fail++;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) n_fail++;
    @(posedge clock);
  endtask
  task automatic do_reset(input logic st);
    standalone_select_pin <= st;
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`PSC_ADDR_MODE, d, r);
    chk("mode", 32'h0, d);
    rd(8'h40, d, r);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(`PSC_ADDR_ENABLE, 32'h13000);
    chk("ext class", 32'h1, {28'h0, ext_class_en});
  endtask
  // semi-auto port 0, others shut down: result table, power orders, strap latch
  task automatic t_semi;
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] rv [6] = '{12'h0FA, 12'h010, 12'h050, 12'h12C, 12'h1F5, 12'h0FA};
    logic [2:0] ev [6] = '{3'h4, 3'h1, 3'h3, 3'h5, 3'h6, 3'h1};
    wr(`PSC_ADDR_MODE, 32'h2);
    wr(`PSC_ADDR_ENABLE, 32'h1);
    for (int i = 0; i < 6; i++) begin
      fe_res <= rv[i];
      fe_vlow <= (i == 5);
      wait (step_req[0]);
      repeat (12) @(posedge clock);
      rd(`PSC_ADDR_STATUS, d, r);
      chk("status", {29'h0, ev[i]}, d & 32'h07070707);
    end
    chk("no power", 32'h0, {28'h0, port_power_en});
    wr(`PSC_ADDR_CMD, 32'h300);
    chk("power on", 32'h1, {28'h0, port_power_en});
    wr(`PSC_ADDR_CMD, 32'h1000);
    chk("power off", 32'h0, {28'h0, port_power_en});
    wr(`PSC_ADDR_CMD, 32'h100);
    current_limit_fault <= 4'h1;
    @(posedge clock);
    current_limit_fault <= 4'h0;
    repeat (3) @(posedge clock);
    chk("fault", 32'h0, {28'h0, port_power_en});
    midspan_select_pin <= 1'b1;
    repeat (5) @(posedge clock);
    chk("mid held", 32'h0, {31'h0, midspan_timing});
    wr(`PSC_ADDR_CMD, 32'h80000000);
    repeat (5) @(posedge clock);
    chk("mid reset", 32'h1, {31'h0, midspan_timing});
  endtask
  // strap-high reset: port 1 asks above the grade limit
  task automatic t_pin;
    req_power_dw <= {20'h0, 10'h385, 10'h384};
    fe_res <= 12'h0FA;
    fe_vlow <= 1'b0;
    do_reset(1'b1);
    for (int n = 0; n < 300 && port_power_en !== 4'hD; n++) @(posedge clock);
    repeat (5) @(posedge clock);
    chk("auto power", 32'hD, {28'h0, port_power_en});
    chk("cut", 32'h27E, {22'h0, overcurrent_cut_threshold[9:0]});
    chk("limit", 32'h352, {22'h0, current_limit_threshold[9:0]});
    disconnect_event <= 4'h1;
    @(posedge clock);
    disconnect_event <= 4'h0;
    repeat (3) @(posedge clock);
    chk("disconnect", 32'h0, {31'h0, port_power_en[0]});
  endtask
  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_regs;
    t_semi;
    t_pin;
    conclude;
  end
  initial begin
    #100us;
    n_fail++;
    conclude;
  end
endmodule // test_pse_port_mode_detect_control
bind psc_port_ctrl psc_port_ctrl_assertions i_chk (.*);
`default_nettype wire
